// ===== shared/csc_pkg.sv
// Package: constants and types for the charger supervisor control block
package csc_pkg;
    // Operating modes
    typedef enum logic [1:0] {
        CSC_MODE_CHARGE,
        CSC_MODE_BOOST,
        CSC_MODE_HIZ
    } csc_mode_t;
    // Adaptor check states
    typedef enum logic [1:0] {
        CSC_AD_IDLE,
        CSC_AD_CHECK,
        CSC_AD_WAIT,
        CSC_AD_GOOD
    } csc_ad_t;
    localparam int          CSC_CLK_HZ        = 10_000_000;
    localparam int          CSC_QUAL_MS       = 30;
    localparam int          CSC_QUAL_CYC      = CSC_CLK_HZ / 1000 * CSC_QUAL_MS;
    localparam int          CSC_RETRY_MS      = 32;
    localparam int          CSC_RETRY_CYC     = CSC_CLK_HZ / 1000 * CSC_RETRY_MS;
    localparam int          CSC_PULSE_CYC     = 16;
    localparam logic [2:0]  CSC_STAT_NORMAL   = 3'h0;
    localparam logic [2:0]  CSC_STAT_OVP      = 3'h1;
    localparam logic [2:0]  CSC_STAT_BAD_AD   = 3'h3;
    localparam logic [2:0]  CSC_STAT_SLEEP    = 3'h2;
    localparam int          CSC_SPECIAL_BIT   = 4;
    localparam logic [1:0]  CSC_ILIM_100      = 2'h0;
    localparam logic [1:0]  CSC_ILIM_500      = 2'h1;
endpackage : csc_pkg

// ===== rtl/csc_top.sv
// Charger supervisor control: mode, adaptor check, input faults, fault pulse
// Operation
// - Three modes: charge, boost, high impedance
// - High impedance halts charging and boosting
// - Host commands mode changes cleanly
// - No host: default timed mode, reset defaults
// - Default mode limit follows on-the-go pin
// - Safety and watchdog timers never end charging
// - No battery detection at power up
// - Overvoltage: converter off, status, one pulse
// - Overvoltage gone: clear fault, resume charge
// - Supply power-on starts check with sink
// - Supply good for qualification time: charge
// - Supply low: sink off, pulse, bad code
// - After bad verdict wait, retry forever
// - Sleep when supply below battery plus offset
// - Sleep holds blocking switch off, and converter off except in boost mode
// - Droop reached: reduce charge current
// - Droop limiting sets special charger bit
// - Default mode holds until host talks
// - Host mode limit from programmed bits
`timescale 1ns/10ps
`default_nettype none
module csc_top
    import csc_pkg::*;
#(
    parameter int QUAL_CYC  = csc_pkg::CSC_QUAL_CYC,
    parameter int RETRY_CYC = csc_pkg::CSC_RETRY_CYC,
    parameter int PULSE_CYC = csc_pkg::CSC_PULSE_CYC
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             vbus_por,
    input  wire logic             above_min_input_threshold,
    input  wire logic             above_input_overvoltage_level,
    input  wire logic             below_sleep_offset,
    input  wire logic             below_input_droop_threshold,
    input  wire logic             otg_pin,
    input  wire logic             host_write,
    input  wire csc_pkg::csc_mode_t host_mode,
    input  wire logic [1:0]       host_ilim,
    output logic                  converter_en,
    output logic                  boost_en,
    output logic                  charge_en,
    output logic                  reverse_block_switch_on,
    output logic                  sink_en,
    output logic                  charge_reduce,
    output logic [1:0]            ilim_sel,
    output logic                  host_mode_active,
    output logic [2:0]            fault_status,
    output logic                  special_charger,
    output logic                  fault_pulse,
    output csc_pkg::csc_mode_t    mode_out
);
    import csc_pkg::*;

    localparam int CW = 24;

    typedef struct packed {
        logic [1:0]  s_min;
        logic [1:0]  s_ovp;
        logic [1:0]  s_slp;
        logic [1:0]  s_dpm;
        csc_mode_t   mode;
        logic        host;
        logic [1:0]  hilim;
        csc_ad_t     ad;
        logic [CW-1:0] cnt;
        logic        ovp;
        logic [CW-1:0] pcnt;
        logic        conv;
        logic        boost;
        logic        chg;
        logic        rbs;
        logic        sink;
        logic        red;
        logic [1:0]  ilim;
        logic [2:0]  stat;
        logic        spec;
        logic        pulse;
    } csc_state_t;

    csc_state_t st_r;
    csc_state_t st_nxt;

    // Counter target helper, cut to counter width
    function automatic logic [CW-1:0] csc_lim(input int n);
        return CW'(n - 1);
    endfunction

    // Next-state logic for the whole block
    always_comb begin
        logic min_ok;
        logic ovp_now;
        logic sleep_now;
        logic start_pulse;
        logic run;
        min_ok      = 1'b0;
        ovp_now     = 1'b0;
        sleep_now   = 1'b0;
        start_pulse = 1'b0;
        run         = 1'b0;
        st_nxt      = st_r;
        // Two-stage synchronisers; logic reads only the second stage,
        // so a metastable first stage never reaches the control paths.
        // Cost: every comparator reaction is two edges late.
        st_nxt.s_min = {st_r.s_min[0], above_min_input_threshold};
        st_nxt.s_ovp = {st_r.s_ovp[0], above_input_overvoltage_level};
        st_nxt.s_slp = {st_r.s_slp[0], below_sleep_offset};
        st_nxt.s_dpm = {st_r.s_dpm[0], below_input_droop_threshold};
        min_ok    = st_r.s_min[1];
        ovp_now   = st_r.s_ovp[1];
        sleep_now = st_r.s_slp[1] && min_ok;

        // Host writes move the mode; first write leaves default mode for good
        if (host_write) begin
            st_nxt.mode  = (host_mode == CSC_MODE_BOOST || host_mode == CSC_MODE_HIZ)
                           ? host_mode : CSC_MODE_CHARGE;
            st_nxt.host  = 1'b1;
            st_nxt.hilim = host_ilim;
        end

        // Overvoltage fault latches until the level clears
        if (ovp_now && !st_r.ovp) begin
            st_nxt.ovp  = 1'b1;
            start_pulse = 1'b1;
        end else if (!ovp_now && st_r.ovp) begin
            st_nxt.ovp  = 1'b0;
        end

        // Adaptor check; a fresh supply power-on restarts it
        if (vbus_por) begin
            st_nxt.ad  = CSC_AD_CHECK;
            st_nxt.cnt = '0;
        end else begin
            case (st_r.ad)
                CSC_AD_IDLE: begin
                    st_nxt.cnt = '0;
                end
                CSC_AD_CHECK: begin
                    if (!min_ok) begin
                        st_nxt.ad   = CSC_AD_WAIT;
                        st_nxt.cnt  = '0;
                        start_pulse = 1'b1;
                    end else if (st_r.cnt == csc_lim(QUAL_CYC)) begin
                        st_nxt.ad = CSC_AD_GOOD;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 1'b1;
                    end
                end
                CSC_AD_WAIT: begin
                    if (st_r.cnt == csc_lim(RETRY_CYC)) begin
                        st_nxt.ad  = CSC_AD_CHECK;
                        st_nxt.cnt = '0;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 1'b1;
                    end
                end
                CSC_AD_GOOD: begin
                    st_nxt.cnt = '0;
                end
                default: begin
                    st_nxt.ad = CSC_AD_IDLE;
                end
            endcase
        end

        // Fault pulse: one fixed-length pulse per event, retrigger ignored while high
        if (start_pulse && !st_r.pulse) begin
            st_nxt.pulse = 1'b1;
            st_nxt.pcnt  = '0;
        end else if (st_r.pulse) begin
            if (st_r.pcnt == csc_lim(PULSE_CYC)) begin
                st_nxt.pulse = 1'b0;
            end else begin
                st_nxt.pcnt = st_r.pcnt + 1'b1;
            end
        end

        // Outputs: timers play no part, battery is never probed
        run          = (st_r.ad == CSC_AD_GOOD) && !st_r.ovp;
        st_nxt.sink  = (st_nxt.ad == CSC_AD_CHECK);
        st_nxt.chg   = run && !sleep_now && (st_r.mode == CSC_MODE_CHARGE);
        st_nxt.boost = !st_r.ovp && (st_r.mode == CSC_MODE_BOOST);
        st_nxt.conv  = st_nxt.chg || st_nxt.boost;
        st_nxt.rbs   = !sleep_now && (st_r.mode != CSC_MODE_HIZ);
        st_nxt.red   = st_nxt.chg && st_r.s_dpm[1];
        st_nxt.spec  = st_nxt.red;
        // Current limit: pin in default mode, programmed bits in host mode
        st_nxt.ilim  = st_r.host ? st_r.hilim
                       : (otg_pin ? CSC_ILIM_500 : CSC_ILIM_100);
        // Status code, bad adaptor has priority as it blocks charging
        if (st_nxt.ad == CSC_AD_WAIT) begin
            st_nxt.stat = CSC_STAT_BAD_AD;
        end else if (st_nxt.ovp) begin
            st_nxt.stat = CSC_STAT_OVP;
        end else if (sleep_now) begin
            st_nxt.stat = CSC_STAT_SLEEP;
        end else begin
            st_nxt.stat = CSC_STAT_NORMAL;
        end

        // Synchronous reset: default timed mode, charge with defaults
        if (!rstn) begin
            st_nxt      = '0;
            st_nxt.mode = CSC_MODE_CHARGE;
            st_nxt.ad   = CSC_AD_CHECK;
            st_nxt.rbs  = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        st_r <= st_nxt;
    end

    assign converter_en            = st_r.conv;
    assign boost_en                = st_r.boost;
    assign charge_en               = st_r.chg;
    assign reverse_block_switch_on = st_r.rbs;
    assign sink_en                 = st_r.sink;
    assign charge_reduce           = st_r.red;
    assign ilim_sel                = st_r.ilim;
    assign host_mode_active        = st_r.host;
    assign fault_status            = st_r.stat;
    assign special_charger         = st_r.spec;
    assign fault_pulse             = st_r.pulse;
    assign mode_out                = st_r.mode;

    // Checks
    AST_HIZ_HALT: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.mode == CSC_MODE_HIZ && !host_write) |=> (!charge_en && !boost_en))
        else $error("high impedance mode still converting");
    AST_HOST_MODE: assert property (@(posedge clk) disable iff (!rstn)
        (host_write && host_mode == CSC_MODE_BOOST) |=> (mode_out == CSC_MODE_BOOST && host_mode_active))
        else $error("host mode write not applied");
    AST_DEF_ILIM: assert property (@(posedge clk) disable iff (!rstn)
        (!host_mode_active && otg_pin) |=> (ilim_sel == CSC_ILIM_500 || host_mode_active))
        else $error("default current limit wrong");
    AST_OVP_OFF: assert property (@(posedge clk) disable iff (!rstn)
        $rose(st_r.s_ovp[1]) |-> ##[1:2] (!converter_en && fault_status == CSC_STAT_OVP || sink_en))
        else $error("overvoltage did not stop converter");
    AST_OVP_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.ovp && !st_r.s_ovp[1]) |=> !st_r.ovp)
        else $error("overvoltage fault not cleared");
    AST_BAD_AD: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.ad == CSC_AD_CHECK && !st_r.s_min[1] && !vbus_por) |=> ##1 (!sink_en && fault_status == CSC_STAT_BAD_AD))
        else $error("bad adaptor not flagged");
    AST_SLEEP: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.s_slp[1] && st_r.s_min[1]) |=> (!reverse_block_switch_on && !converter_en))
        else $error("sleep did not switch off");
    AST_SPECIAL: assert property (@(posedge clk) disable iff (!rstn)
        special_charger == charge_reduce)
        else $error("special charger bit mismatch");
    AST_PULSE_LEN: assert property (@(posedge clk) disable iff (!rstn)
        $rose(fault_pulse) |-> fault_pulse [*2])
        else $error("fault pulse too short");

    // Reset checks run without a disable so the reset values themselves are seen
    AST_RESET_STATE: assert property (@(posedge clk)
        !rstn |=> (mode_out == CSC_MODE_CHARGE && !host_mode_active && reverse_block_switch_on))
        else $error("reset did not restore default timed mode");
    AST_RESET_QUIET: assert property (@(posedge clk)
        !rstn |=> (!fault_pulse && !converter_en && !boost_en && !charge_en))
        else $error("reset left converter or pulse active");
    AST_RESET_CHECK: assert property (@(posedge clk)
        !rstn |=> (st_r.ad == CSC_AD_CHECK))
        else $error("reset did not start adaptor check");

    // Mode handling: only host writes move the mode, and only to legal codes
    AST_THREE_MODES: assert property (@(posedge clk) disable iff (!rstn)
        2'(mode_out) != 2'h3)
        else $error("illegal operating mode");
    AST_MODE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        !host_write |=> $stable(mode_out))
        else $error("mode changed without a host write");
    AST_HOST_HIZ: assert property (@(posedge clk) disable iff (!rstn)
        (host_write && host_mode == CSC_MODE_HIZ) |=> (mode_out == CSC_MODE_HIZ))
        else $error("high impedance write not applied");
    AST_HIZ_RBS: assert property (@(posedge clk) disable iff (!rstn)
        (mode_out == CSC_MODE_HIZ) |=> !reverse_block_switch_on)
        else $error("high impedance mode left blocking switch on");
    AST_BOOST_GATE: assert property (@(posedge clk) disable iff (!rstn)
        boost_en |-> ($past(mode_out) == CSC_MODE_BOOST))
        else $error("boost outside boost mode");

    // Default timed mode lasts until the first host write, then host mode stays
    AST_HOST_STICKY: assert property (@(posedge clk) disable iff (!rstn)
        host_mode_active |=> host_mode_active)
        else $error("host mode dropped");
    AST_NO_HOST: assert property (@(posedge clk) disable iff (!rstn)
        (!host_write && !host_mode_active) |=> !host_mode_active)
        else $error("host mode entered without a write");
    AST_DEF_ILIM_LO: assert property (@(posedge clk) disable iff (!rstn)
        (!host_mode_active && !otg_pin) |=> (ilim_sel == CSC_ILIM_100))
        else $error("default low current limit wrong");
    AST_HOST_ILIM: assert property (@(posedge clk) disable iff (!rstn)
        (host_write ##1 !host_write) |=> (ilim_sel == $past(host_ilim, 2)))
        else $error("programmed current limit not applied");

    // Charging needs a good adaptor and no overvoltage
    AST_CHG_GOOD: assert property (@(posedge clk) disable iff (!rstn)
        charge_en |-> ($past(st_r.ad) == CSC_AD_GOOD && !$past(st_r.ovp)))
        else $error("charging without a good adaptor");
    AST_OVP_NO_CONV: assert property (@(posedge clk) disable iff (!rstn)
        st_r.ovp |=> !converter_en)
        else $error("converter on during overvoltage");
    AST_OVP_PULSE: assert property (@(posedge clk) disable iff (!rstn)
        $rose(st_r.ovp) |-> (fault_pulse || $past(fault_pulse)))
        else $error("overvoltage gave no fault pulse");
    AST_OVP_STATUS: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.ovp && st_r.ad != CSC_AD_WAIT) |-> (fault_status == CSC_STAT_OVP))
        else $error("overvoltage status code wrong");

    // Adaptor check sequencing
    AST_POR_RESTART: assert property (@(posedge clk) disable iff (!rstn)
        vbus_por |=> (st_r.ad == CSC_AD_CHECK && sink_en && st_r.cnt == '0))
        else $error("supply power-on did not restart check");
    AST_QUAL_GOOD: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.ad == CSC_AD_CHECK && st_r.s_min[1] && !vbus_por && st_r.cnt == csc_lim(QUAL_CYC))
        |=> (st_r.ad == CSC_AD_GOOD))
        else $error("qualified adaptor not declared good");
    AST_BAD_PULSE: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.ad == CSC_AD_CHECK && !st_r.s_min[1] && !vbus_por && !fault_pulse) |=> fault_pulse)
        else $error("bad adaptor gave no fault pulse");
    AST_RETRY: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.ad == CSC_AD_WAIT && !vbus_por && st_r.cnt == csc_lim(RETRY_CYC))
        |=> (st_r.ad == CSC_AD_CHECK && sink_en))
        else $error("adaptor check not retried");

    // Sleep and droop behaviour
    AST_SLEEP_NO_CHG: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.s_slp[1] && st_r.s_min[1]) |=> !charge_en)
        else $error("charging during sleep");
    AST_DROOP_ONLY_CHG: assert property (@(posedge clk) disable iff (!rstn)
        charge_reduce |-> charge_en)
        else $error("droop reduction while not charging");
    AST_DROOP_REDUCE: assert property (@(posedge clk) disable iff (!rstn)
        (st_r.s_dpm[1] && st_r.ad == CSC_AD_GOOD && !st_r.ovp && !st_r.s_slp[1]
         && mode_out == CSC_MODE_CHARGE) |=> charge_reduce)
        else $error("droop did not reduce charge current");

    // Pulse counter never runs past its end value while the pulse is high
    AST_PULSE_MAX: assert property (@(posedge clk) disable iff (!rstn)
        fault_pulse |-> (st_r.pcnt <= csc_lim(PULSE_CYC)))
        else $error("fault pulse too long");
endmodule // csc_top
`default_nettype wire

// ===== bench/csc_host_model.sv
// Host processor model that issues mode and current limit writes
`timescale 1ns/10ps
`default_nettype none
module csc_host_model (
    input  wire logic          clk,
    output logic               host_write,
    output csc_pkg::csc_mode_t host_mode,
    output logic [1:0]         host_ilim
);
    import csc_pkg::*;
    // Idle with no write pending
    initial begin
        host_write = 1'b0;
        host_mode  = CSC_MODE_CHARGE;
        host_ilim  = 2'h0;
    end
    // One write held for one edge; data is then scrambled so stale values never count
    task automatic send(input csc_mode_t mode, input logic [1:0] ilim);
        @(posedge clk);
        #1;
        host_write = 1'b1;
        host_mode  = mode;
        host_ilim  = ilim;
        @(posedge clk);
        #1;
        host_write = 1'b0;
        host_mode  = csc_mode_t'(~mode);
        host_ilim  = ~ilim;
    endtask
endmodule // csc_host_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking testbench for the charger supervisor control block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import csc_pkg::*;
    localparam int QC = 20;
    localparam int RC = 30;
    localparam int PC = 4;
    logic       clk, rstn, por, vmin, ovp, slp, droop, otg, hw;
    logic       conv, bst, chg, rbs, sink, red, hma, spc, fp;
    logic [1:0] hi, ilim;
    logic [2:0] fst;
    csc_mode_t  hm, mo;
    int         bad_count = 0;
    int         check_count = 0;
    csc_top #(.QUAL_CYC(QC), .RETRY_CYC(RC), .PULSE_CYC(PC)) dut (
        .clk(clk), .rstn(rstn), .vbus_por(por), .above_min_input_threshold(vmin),
        .above_input_overvoltage_level(ovp), .below_sleep_offset(slp),
        .below_input_droop_threshold(droop), .otg_pin(otg), .host_write(hw),
        .host_mode(hm), .host_ilim(hi), .converter_en(conv), .boost_en(bst),
        .charge_en(chg), .reverse_block_switch_on(rbs), .sink_en(sink),
        .charge_reduce(red), .ilim_sel(ilim), .host_mode_active(hma),
        .fault_status(fst), .special_charger(spc), .fault_pulse(fp), .mode_out(mo));
    csc_host_model host (.clk(clk), .host_write(hw), .host_mode(hm), .host_ilim(hi));
    // Free running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [2:0] exp, input logic [2:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Step n edges and land just after the last, where outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Wait a bounded time for a pulse, then measure its width; capped below 8 to avoid aliasing
    task automatic pulse_chk();
        int n = 0;
        for (int i = 0; i < 8 && fp !== 1'b1; i++) cyc(1);
        while (fp === 1'b1 && n < 7) begin
            n++;
            cyc(1);
        end
        chk("pulse_len", 3'(PC), 3'(n));
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic t_reset();
        chk("conv", 0, conv);
        chk("rbs", 1, rbs);
        chk("mode", 3'(CSC_MODE_CHARGE), 3'(mo));
        chk("hma", 0, hma);
        chk("fp", 0, fp);
    endtask
    // Supply is low for the first check, then recovers before the retry
    task automatic t_adaptor();
        pulse_chk();
        chk("sink", 0, sink);
        chk("fst", 3'(CSC_STAT_BAD_AD), fst);
        vmin = 1'b1;
        cyc(RC);
        chk("sink_retry", 1, sink);
        cyc(QC + 4);
        chk("chg", 1, chg);
        chk("fst", 3'(CSC_STAT_NORMAL), fst);
        chk("ilim_lo", 3'(CSC_ILIM_100), 3'(ilim));
        otg = 1'b1;
        cyc(4);
        chk("ilim_hi", 3'(CSC_ILIM_500), 3'(ilim));
    endtask
    task automatic t_ovp();
        ovp = 1'b1;
        pulse_chk();
        chk("conv", 0, conv);
        chk("fst", 3'(CSC_STAT_OVP), fst);
        ovp = 1'b0;
        cyc(4);
        chk("fst", 3'(CSC_STAT_NORMAL), fst);
        chk("chg", 1, chg);
        chk("conv", 1, conv);
    endtask
    task automatic t_sleep();
        slp = 1'b1;
        cyc(4);
        chk("fst", 3'(CSC_STAT_SLEEP), fst);
        chk("rbs", 0, rbs);
        chk("conv", 0, conv);
        slp = 1'b0;
        cyc(4);
        chk("rbs", 1, rbs);
    endtask
    task automatic t_droop();
        droop = 1'b1;
        cyc(4);
        chk("red", 1, red);
        chk("spc", 1, spc);
        droop = 1'b0;
        cyc(4);
        chk("spc", 0, spc);
    endtask
    // Host walks through all three modes, then the supply restarts
    task automatic t_host();
        host.send(CSC_MODE_HIZ, 2'h0);
        cyc(2);
        chk("mode", 3'(CSC_MODE_HIZ), 3'(mo));
        chk("hma", 1, hma);
        chk("chg", 0, chg);
        chk("conv", 0, conv);
        host.send(CSC_MODE_BOOST, 2'h3);
        cyc(2);
        chk("bst", 1, bst);
        chk("ilim", 3'h3, 3'(ilim));
        host.send(CSC_MODE_CHARGE, 2'h2);
        otg = 1'b0;
        cyc(3);
        chk("chg", 1, chg);
        chk("ilim", 3'h2, 3'(ilim));
        por = 1'b1;
        cyc(1);
        por = 1'b0;
        cyc(2);
        chk("sink_por", 1, sink);
    endtask
    // Main sequence; supply starts low so the first check fails
    initial begin
        {rstn, por, vmin, ovp, slp, droop, otg} = 7'h00;
        cyc(8);
        t_reset();
        rstn = 1'b1;
        t_adaptor();
        t_ovp();
        t_sleep();
        t_droop();
        t_host();
        print_verdict();
    end
    // Whole run needs well under 500 cycles
    initial begin
        #(2000 * 100);
        bad_count++;
        print_verdict();
    end
endmodule // tb
`default_nettype wire
